/* File: adsq_pkg.sv */
// constants and bus carriers for the converter sequencer
package adsq_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int RES_W = 8;
   localparam int CH_W = 5;
   localparam int CYC_W = 5;
   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_STATCTL = 8'h1C;
   localparam logic [ADDR_W-1:0] IDX_RESULT = 8'h1D;
   localparam logic [ADDR_W-1:0] ADDR_STATCTL = {IDX_STATCTL[5:0], 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_RESULT = {IDX_RESULT[5:0], 2'h0};
   localparam int BIT_CONV_COMPLETE_FLAG = 7;
   localparam int BIT_RCSEL = 6;
   localparam int BIT_PWR = 5;
   localparam logic [CH_W-1:0] CH_RESET = 5'h00;
   localparam logic [RES_W-1:0] RESULT_RESET = 8'h00;
   localparam logic [CH_W-1:0] CH_LAST_LOW = 5'h07;
   localparam logic [CH_W-1:0] CH_LAST_HIGH = 5'h0F;
   localparam logic [CH_W-1:0] CH_REF_HIGH = 5'h10;
   localparam logic [CH_W-1:0] CH_REF_MID = 5'h11;
   localparam logic [CH_W-1:0] CH_REF_LOW = 5'h12;
   localparam logic [CH_W-1:0] CH_TEST = 5'h13;
   localparam int CONV_CYCLES = 32;
   localparam logic [CYC_W-1:0] CYC_LAST = 5'h1F;
   localparam logic [RES_W-1:0] SAR_MSB = 8'h80;
   localparam logic [RES_W-1:0] CH13_VALUE = 8'h00;
   localparam int CLK_HZ = 10_000_000;
   localparam int CONV_HZ = 1_000_000;
   localparam int CONV_DIV = CLK_HZ / CONV_HZ;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } adsq_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } adsq_axi_rsp_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_RESOLVE = 2'b10,
      ST_FINISH = 2'b11
   } adsq_state_t;
endpackage

/* File: adsq_sequencer.sv */
// converter sequencer: register slave, clock select and approximation
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module adsq_sequencer #(
   parameter int CONV_DIV = adsq_pkg::CONV_DIV
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire adsq_pkg::adsq_axi_req_t i_axi,
   output adsq_pkg::adsq_axi_rsp_t o_axi,
   input wire logic i_rc_tick,
   input wire logic i_cmp_above,
   input wire logic i_stop_mode,
   input wire logic i_single_chip,
   output logic [adsq_pkg::CH_W-1:0] o_mux_select,
   output logic [adsq_pkg::RES_W-1:0] o_dac_code,
   output logic o_sample,
   output logic o_pump_on,
   output logic o_rc_osc_on
);
   import adsq_pkg::*;

   localparam int DIV_W = $clog2(CONV_DIV + 1);
   localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CONV_DIV - 1);
   localparam int PERIOD_TICKS = CONV_CYCLES - 1;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] t);
      addr_hit = (a[ADDR_W-1:2] == t[ADDR_W-1:2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_s1;
   logic rst_n;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus slave
   logic aw_held, next_aw_held;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic w_held, next_w_held;
   logic [DATA_W-1:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic awready, next_awready;
   logic wready, next_wready;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic arready, next_arready;
   logic rvalid, next_rvalid;
   logic [DATA_W-1:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;
   logic do_write;
   logic rd_take;
   logic wr_ctl;
   logic rd_result;

   // control and result state, declared here for the read mux
   logic conv_complete_flag, next_conv_complete_flag;
   logic rcsel, next_rcsel;
   logic pwr, next_pwr;
   logic [CH_W-1:0] ch, next_ch;
   logic [RES_W-1:0] result, next_result;

   assign do_write = aw_held & w_held & ~bvalid;
   assign rd_take = i_axi.arvalid & arready;
   assign wr_ctl = do_write & addr_hit(aw_addr, ADDR_STATCTL) & w_strb[0];
   assign rd_result = rd_take & addr_hit(i_axi.araddr, ADDR_RESULT);

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (i_axi.awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = i_axi.awaddr;
      end
      if (i_axi.wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_data = i_axi.wdata;
         next_w_strb = i_axi.wstrb;
      end
      if (bvalid && i_axi.bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         // result register is read-only: writes are accepted and dropped
         if (addr_hit(aw_addr, ADDR_STATCTL) ||
             addr_hit(aw_addr, ADDR_RESULT)) begin
            next_bresp = RESP_OKAY;
         end else begin
            next_bresp = RESP_SLVERR;
         end
      end
      if (rvalid && i_axi.rready) begin
         next_rvalid = 1'b0;
      end
      if (rd_take) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         if (addr_hit(i_axi.araddr, ADDR_STATCTL)) begin
            next_rdata = {24'h000000, conv_complete_flag, rcsel, pwr, ch};
         end else if (rd_result) begin
            next_rdata = {24'h000000, result};
         end else begin
            next_rdata = 32'h00000000;
            next_rresp = RESP_SLVERR;
         end
      end
      next_awready = ~next_aw_held & ~next_bvalid;
      next_wready = ~next_w_held & ~next_bvalid;
      next_arready = ~next_rvalid;
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= 4'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   assign o_axi = '{awready: awready, wready: wready, bvalid: bvalid,
                    bresp: bresp, arready: arready, rvalid: rvalid,
                    rdata: rdata, rresp: rresp};

   ////////////////////////////////////////////////////////////////////////
   // conversion clock: bus divider or rc oscillator ticks
   logic [DIV_W-1:0] div_cnt, next_div_cnt;
   logic armed, next_armed;
   logic conv_en;
   logic conv_tick;

   // rc ticks are taken on the bus clock, so at most one converter cycle passes per bus cycle
   assign conv_en = armed & pwr & ~i_stop_mode;
   assign conv_tick = conv_en & (rcsel ? i_rc_tick
                                       : (div_cnt == DIV_MAX));

   always_comb begin
      next_div_cnt = div_cnt + DIV_W'(1);
      if (div_cnt == DIV_MAX || i_stop_mode) begin
         next_div_cnt = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // successive approximation sequencer
   adsq_state_t state, next_state;
   logic [CYC_W-1:0] cyc, next_cyc;
   logic [RES_W-1:0] dac, next_dac;
   logic sample, next_sample;
   logic complete;
   logic [RES_W-1:0] conv_value;

   assign complete = conv_tick & (state == ST_FINISH) & (cyc == CYC_LAST);
   // reserved test channel reads as zero in single-chip operation
   assign conv_value = (i_single_chip && ch == CH_TEST) ? CH13_VALUE
                                                        : dac;

   always_comb begin
      logic [2:0] bidx;
      bidx = 3'(RES_W - 1) - 3'(cyc - 5'h01);
      next_state = state;
      next_cyc = cyc;
      next_dac = dac;
      next_sample = 1'b0;
      next_armed = armed;
      if (wr_ctl) begin
         next_armed = 1'b1;
         next_state = ST_SAMPLE;
         next_cyc = '0;
         next_dac = '0;
      end else if (i_stop_mode) begin
         // abort: the next conversion starts over after stop
         if (armed) begin
            next_state = ST_SAMPLE;
         end
         next_cyc = '0;
      end else if (conv_tick) begin
         next_cyc = cyc + 5'h01;
         case (state)
            ST_SAMPLE: begin
               next_sample = 1'b1;
               next_dac = SAR_MSB;
               next_state = ST_RESOLVE;
            end
            ST_RESOLVE: begin
               // keep the trial bit while the input is at or above it
               next_dac[bidx] = i_cmp_above;
               if (bidx != 3'h0) begin
                  next_dac[bidx - 3'h1] = 1'b1;
               end else begin
                  next_state = ST_FINISH;
               end
            end
            ST_FINISH: begin
               if (cyc == CYC_LAST) begin
                  next_state = ST_SAMPLE;
               end
            end
            ST_IDLE: begin
               next_cyc = cyc;
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         cyc <= '0;
         dac <= '0;
         sample <= 1'b0;
         armed <= 1'b0;
         div_cnt <= '0;
      end else begin
         state <= next_state;
         cyc <= next_cyc;
         dac <= next_dac;
         sample <= next_sample;
         armed <= next_armed;
         div_cnt <= next_div_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status/control and result registers
   logic pump_on, next_pump_on;
   logic rc_osc_on, next_rc_osc_on;

   // wait mode is not an input: the converter just keeps running
   always_comb begin
      next_rcsel = rcsel;
      next_pwr = pwr;
      next_ch = ch;
      next_conv_complete_flag = conv_complete_flag;
      next_result = result;
      if (wr_ctl) begin
         next_rcsel = w_data[BIT_RCSEL];
         next_pwr = w_data[BIT_PWR];
         next_ch = w_data[CH_W-1:0];
         next_conv_complete_flag = 1'b0;
      end
      if (rd_result) begin
         next_conv_complete_flag = 1'b0;
      end
      if (complete) begin
         next_conv_complete_flag = 1'b1;
         next_result = conv_value;
      end
      next_pump_on = pwr & ~i_stop_mode;
      next_rc_osc_on = rcsel & ~i_stop_mode;
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rcsel <= 1'b0;
         pwr <= 1'b0;
         ch <= CH_RESET;
         conv_complete_flag <= 1'b0;
         result <= RESULT_RESET;
         pump_on <= 1'b0;
         rc_osc_on <= 1'b0;
      end else begin
         rcsel <= next_rcsel;
         pwr <= next_pwr;
         ch <= next_ch;
         conv_complete_flag <= next_conv_complete_flag;
         result <= next_result;
         pump_on <= next_pump_on;
         rc_osc_on <= next_rc_osc_on;
      end
   end

   // codes 0-7 low pins, 8-15 high pins, 16-19 internal points
   assign o_mux_select = ch;
   assign o_dac_code = dac;
   assign o_sample = sample;
   assign o_pump_on = pump_on;
   assign o_rc_osc_on = rc_osc_on;

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [5:0] period_ticks;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         period_ticks <= '0;
      end else if (wr_ctl || i_stop_mode || complete) begin
         period_ticks <= '0;
      end else if (conv_tick) begin
         period_ticks <= period_ticks + 6'h01;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   AST_CONV_COMPLETE_FLAG_SET: assert property (
      complete |=> conv_complete_flag)
      else $error("complete flag not set after a conversion");

   AST_WRITE_CLEARS: assert property (
      wr_ctl && !complete |=> !conv_complete_flag && state == ST_SAMPLE && cyc == 5'h00)
      else $error("control write did not clear flag and restart");

   AST_READ_CLEARS: assert property (
      rd_result && !complete |=> !conv_complete_flag && rvalid &&
      rdata[7:0] == $past(result))
      else $error("result read did not clear the flag");

   AST_PERIOD: assert property (
      complete |-> period_ticks == 6'(PERIOD_TICKS))
      else $error("conversion period is not 32 converter cycles");

   AST_RESULT_LOAD: assert property (
      complete |=> result == $past(conv_value))
      else $error("result not loaded with the new conversion");

   AST_CLOCK_SOURCE: assert property (
      conv_tick |-> (rcsel ? i_rc_tick : div_cnt == DIV_MAX) && pwr)
      else $error("conversion tick from the wrong clock source");

   AST_TEST_CH_ZERO: assert property (
      complete && i_single_chip && ch == CH_TEST |=> result == CH13_VALUE)
      else $error("reserved channel did not convert to zero");

   AST_STOP_OFF: assert property (
      i_stop_mode |-> !conv_tick ##1 !o_pump_on && !o_rc_osc_on)
      else $error("analog section still active in stop");

   AST_STOP_KEEPS: assert property (
      i_stop_mode && !wr_ctl && !rd_result |=> $stable(result) &&
      $stable({conv_complete_flag, rcsel, pwr, ch}))
      else $error("stop changed result or control register");

   AST_SAMPLE_FIRST: assert property (
      conv_tick && state == ST_SAMPLE && !wr_ctl |=> o_sample &&
      o_dac_code == SAR_MSB)
      else $error("conversion did not open with a sample at mid code");
endmodule

/* File: adsq_analog_model.sv */
// analog side model: input levels, sample hold and comparator
`timescale 1ns/100ps
module adsq_analog_model (
   input wire logic i_clk,
   input wire logic [adsq_pkg::CH_W-1:0] i_mux_select,
   input wire logic [adsq_pkg::RES_W-1:0] i_dac_code,
   input wire logic i_sample,
   input wire logic i_pump_on,
   input wire logic [20*adsq_pkg::RES_W-1:0] i_levels,
   output logic o_cmp_above
);
   import adsq_pkg::*;
   logic [RES_W-1:0] held = 8'h00;
   logic toggle = 1'b0;
   //////////////////////////////////////////////////
   // input is frozen at the start of each conversion
   always @(posedge i_clk) begin
      toggle <= ~toggle;
      if (i_sample) begin
         held <= i_levels[i_mux_select*RES_W +: RES_W];
      end
   end
   // an unpowered comparator gives no usable answer
   assign o_cmp_above = i_pump_on ? (held >= i_dac_code) : toggle;
endmodule

/* File: adsq_sequencer_tb.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module adsq_sequencer_tb;
   import adsq_pkg::*;
   localparam int DIV = 2;
   localparam int RC_PER = 3;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   adsq_axi_req_t axi = '0;
   adsq_axi_rsp_t o_axi;
   logic i_rc_tick = 1'b0;
   logic i_stop_mode = 1'b0;
   logic i_single_chip = 1'b1;
   logic cmp_above;
   logic [CH_W-1:0] mux_select;
   logic [RES_W-1:0] dac_code;
   logic sample, pump_on, rc_osc_on;
   logic [20*RES_W-1:0] levels = '0;
   logic [7:0] dd;
   logic [41:0] re;
   int rc_cnt = 0;
   int mismatches = 0;
   int checked = 0;
   integer seed = 61;
   logic [41:0] rq[$];
   logic [1:0] bq[$];

   adsq_sequencer #(.CONV_DIV(DIV)) adsq_sequencer_i (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_axi(axi), .o_axi(o_axi),
      .i_rc_tick(i_rc_tick), .i_cmp_above(cmp_above),
      .i_stop_mode(i_stop_mode), .i_single_chip(i_single_chip),
      .o_mux_select(mux_select), .o_dac_code(dac_code), .o_sample(sample),
      .o_pump_on(pump_on), .o_rc_osc_on(rc_osc_on));

   adsq_analog_model adsq_analog_model_i (
      .i_clk(i_clk), .i_mux_select(mux_select), .i_dac_code(dac_code),
      .i_sample(sample), .i_pump_on(pump_on), .i_levels(levels),
      .o_cmp_above(cmp_above));

   always #50 i_clk = ~i_clk;

   always @(posedge i_clk) begin
      rc_cnt <= (rc_cnt == RC_PER - 1) ? 0 : rc_cnt + 1;
      i_rc_tick <= (rc_cnt == 0);
   end

   //////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(inout int n);
      @(posedge i_clk);
      n++;
      if (n > 3000) begin
         mismatches++;
         finish_test();
      end
   endtask

   // answers are compared here against the oldest note
   always @(posedge i_clk) begin
      if (o_axi.rvalid && axi.rready) begin
         re = rq.pop_front();
         cmp("read data", {re[33:32], re[7:0] & re[41:34]},
             {o_axi.rresp, o_axi.rdata[7:0] & re[41:34]});
         cmp("read upper", 32'h0, {8'h00, o_axi.rdata[31:8]});
      end
      if (o_axi.bvalid && axi.bready) begin
         cmp("write resp", bq.pop_front(), o_axi.bresp);
      end
   end

   //////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      int n;
      logic aw, w, b;
      logic [31:0] r;
      n = 0;
      aw = 1'b0;
      w = 1'b0;
      b = 1'b0;
      r = $random(seed);
      bq.push_back(er);
      @(posedge i_clk);
      axi.awvalid <= 1'b1;
      axi.awaddr <= a;
      axi.wvalid <= 1'b1;
      axi.wdata <= {r[23:0], d};
      axi.wstrb <= s;
      axi.bready <= 1'b1;
      while (!b) begin
         tick(n);
         if (!aw && o_axi.awready) begin
            aw = 1'b1;
            axi.awvalid <= 1'b0;
         end
         if (!w && o_axi.wready) begin
            w = 1'b1;
            axi.wvalid <= 1'b0;
         end
         if (o_axi.bvalid) begin
            b = 1'b1;
            axi.bready <= 1'b0;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e, input logic [1:0] er,
                     output logic [7:0] d);
      int n;
      logic ar, r;
      n = 0;
      ar = 1'b0;
      r = 1'b0;
      rq.push_back({m, er, 24'h0, e});
      @(posedge i_clk);
      axi.arvalid <= 1'b1;
      axi.araddr <= a;
      axi.rready <= 1'b1;
      while (!r) begin
         tick(n);
         if (!ar && o_axi.arready) begin
            ar = 1'b1;
            axi.arvalid <= 1'b0;
         end
         if (o_axi.rvalid) begin
            r = 1'b1;
            d = o_axi.rdata[7:0];
            axi.rready <= 1'b0;
         end
      end
   endtask

   // control reads with the flag left out until it shows set
   task automatic poll(input logic [7:0] c);
      int k;
      k = 0;
      dd = 8'h00;
      while (dd[7] !== 1'b1) begin
         rd(ADDR_STATCTL, 8'h7F, c, RESP_OKAY, dd);
         k++;
         if (k > 300) begin
            mismatches++;
            finish_test();
         end
      end
   endtask

   task automatic wsmp(output int n);
      n = 0;
      tick(n);
      while (sample !== 1'b1) begin
         tick(n);
      end
   endtask

   task automatic meas(input int e);
      int n;
      wsmp(n);
      wsmp(n);
      cmp("sample period", e, n);
   endtask

   task automatic setlv(input logic [4:0] ch, output logic [7:0] v);
      v = 8'($random(seed));
      if (ch == CH_REF_HIGH) v = 8'hFF;
      if (ch == CH_REF_MID) v = 8'h80;
      if (ch == CH_REF_LOW) v = 8'h00;
      levels[ch*8 +: 8] <= v;
   endtask

   //////////////////////////////////////////////////
   initial begin
      int n;
      logic [7:0] v, c, ev;
      logic [CH_W-1:0] ch;
      repeat (12) @(posedge i_clk);
      cmp("reset outputs", 32'h0, {o_axi.awready, pump_on, rc_osc_on});
      i_rst_n <= 1'b1;
      rd(ADDR_STATCTL, 8'hFF, 8'h00, RESP_OKAY, dd);
      rd(ADDR_RESULT, 8'hFF, RESULT_RESET, RESP_OKAY, dd);
      rd(8'h00, 8'hFF, 8'h00, RESP_SLVERR, dd);
      wr(8'h00, 8'h25, 4'hF, RESP_SLVERR);
      wr(ADDR_RESULT, 8'h5A, 4'hF, RESP_OKAY);
      wr(ADDR_STATCTL, 8'h25, 4'hE, RESP_OKAY);
      rd(ADDR_RESULT, 8'hFF, 8'h00, RESP_OKAY, dd);
      rd(ADDR_STATCTL, 8'hFF, 8'h00, RESP_OKAY, dd);
      cmp("pump idle", 32'h0, pump_on);
      // every channel code; the last pass repeats code 19 off single-chip
      for (int i = 0; i <= 20; i++) begin
         ch = (i > 19) ? CH_TEST : i[4:0];
         i_single_chip <= (i < 20);
         setlv(ch, v);
         c = {3'b001, ch};
         wr(ADDR_STATCTL, c, 4'hF, RESP_OKAY);
         rd(ADDR_STATCTL, 8'hFF, c, RESP_OKAY, dd);
         cmp("mux select", ch, mux_select);
         cmp("pump on", 32'h1, pump_on);
         poll(c);
         ev = (ch == CH_TEST && i < 20) ? CH13_VALUE : v;
         rd(ADDR_RESULT, 8'hFF, ev, RESP_OKAY, dd);
         rd(ADDR_STATCTL, 8'hFF, c, RESP_OKAY, dd);
         setlv(ch, v);
         ev = (ch == CH_TEST && i < 20) ? CH13_VALUE : v;
         repeat (3 * CONV_CYCLES * DIV) @(posedge i_clk);
         rd(ADDR_STATCTL, 8'hFF, c | 8'h80, RESP_OKAY, dd);
         rd(ADDR_RESULT, 8'hFF, ev, RESP_OKAY, dd);
      end
      c = 8'h65;
      wr(ADDR_STATCTL, c, 4'hF, RESP_OKAY);
      meas(CONV_CYCLES * RC_PER);
      cmp("rc osc on", 32'h1, rc_osc_on);
      poll(c);
      i_stop_mode <= 1'b1;
      repeat (3) @(posedge i_clk);
      cmp("stop analog", 32'h0, {pump_on, rc_osc_on});
      n = 0;
      repeat (300) begin
         @(posedge i_clk);
         n += sample;
      end
      cmp("stop samples", 32'h0, n);
      rd(ADDR_STATCTL, 8'hFF, c | 8'h80, RESP_OKAY, dd);
      rd(ADDR_RESULT, 8'hFF, levels[47:40], RESP_OKAY, dd);
      i_stop_mode <= 1'b0;
      meas(CONV_CYCLES * RC_PER);
      cmp("stop exit", 32'h3, {pump_on, rc_osc_on});
      wr(ADDR_STATCTL, 8'h25, 4'hF, RESP_OKAY);
      meas(CONV_CYCLES * DIV);
      wr(ADDR_STATCTL, 8'h00, 4'hF, RESP_OKAY);
      repeat (3) @(posedge i_clk);
      cmp("power off", 32'h0, {pump_on, rc_osc_on});
      finish_test();
   end
endmodule
